// ---- rtl/clock_supervisor.v ----
// Clock supervisor: two-speed start-up, fail-safe clock monitor, sleep entry and wake rules.
// Assumes the slow RC clock, primary clock and secondary clock arrive as asynchronous pins,
// each much slower than i_clk, and that the core reports sleep and wake events as one-cycle pulses.
`timescale 1ns/1ps
`include "clock_supervisor_regs.vh"

//
// Contract
// - After reset or wake, execute from the slow internal RC at 31.25 kHz; code moves to primary at once unless two-speed start-up is on.
// - Start-up timer counts 1024 primary cycles before primary is stable.
// - On timer expiry, wait for RC falling edge, then set primary-running flag.
// - Hold system clock low for eight new-clock falling edges, then select primary.
// - Fail monitor works only when its configuration enable is set.
// - On failure raise fail flag and run from internal oscillator until fail-safe ends.
// - Fail-safe ends on reset, sleep, or any control register write.
// - In fail-safe the internal frequency follows the select field; software may switch.
// - Monitor sample clock is the slow RC divided by 64.
// - Latch clears on sample rise, sets on system falling edge; clear at fall fails.
// - Reset in fail-safe with crystal: run internal until 1024-cycle timer completes; code resets config_q to zero, so it selects primary at once.
// - Enabling the fail monitor also enables two-speed start-up.
// - Reset in fail-safe with external clock or RC returns to primary at once.
// - After fail-safe ends, keep monitoring; secondary failure switches to internal.
// - A detected failure forces the source select field to binary 10.
// - Crystal modes use internal clock until timer expiry, then RC samples again.
// - A crystal failing during the start-up timer is never flagged.
// - External clock, RC or internal RC primaries are monitored right after reset; code resets config_q to zero, so the monitor starts disabled.
// - Sleep clears watchdog, clears power-down flag, sets time-out, stops driver.
// - Wake on master clear, watchdog time-out or enabled interrupt.
// - Interrupt wake ignores global enable; with it set, vector after next instruction.
// - Sleep with an enabled interrupt pending acts as no-operation.
// - Any reset zeroes the internal frequency select field.
// - Two-speed start-up is off for non-crystal primary modes.
module clock_supervisor (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_rc_clk,
  input wire i_primary_clk,
  input wire i_secondary_clk,
  input wire i_sleep_op,
  input wire i_watchdog_clear_op,
  input wire i_watchdog_timeout,
  input wire i_irq_pending,
  input wire i_global_irq_enable,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  output reg [1:0] o_clk_sel,
  output reg o_clk_hold_low,
  output reg o_osc_driver_en,
  output reg o_sleeping,
  output reg o_watchdog_reset,
  output reg o_wake,
  output reg o_irq_vector,
  output reg o_osc_fail_irq
);

  // --------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // --------------------------------------------------------------------------
  reg [1:0] rst_sync_q;
  wire rst_n;
  reg [2:0] pin_meta_q;
  reg [2:0] pin_sync_q;
  reg [2:0] pin_prev_q;
  wire rc_fall;
  wire pri_fall;
  wire sec_fall;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 3'b000;
      pin_sync_q <= 3'b000;
      pin_prev_q <= 3'b000;
    end else begin
      pin_meta_q <= {i_secondary_clk, i_primary_clk, i_rc_clk};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end
  assign rc_fall = pin_prev_q[0] & ~pin_sync_q[0];
  assign pri_fall = pin_prev_q[1] & ~pin_sync_q[1];
  assign sec_fall = pin_prev_q[2] & ~pin_sync_q[2];

  // --------------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------------
  localparam [4:0] ST_INTERNAL = 5'b00001;
  localparam [4:0] ST_OST = 5'b00010;
  localparam [4:0] ST_WAIT_RC = 5'b00100;
  localparam [4:0] ST_HOLD = 5'b01000;
  localparam [4:0] ST_PRIMARY = 5'b10000;
  // Reset image of the control register; each field takes only its own slice of it.
  localparam [7:0] CTRL_RESET = `RST_CTRL;

  reg [4:0] state_q;
  reg [1:0] scs_q;
  reg [2:0] internal_freq_select_q;
  reg [7:0] config_q;
  reg running_flag_q;
  reg fail_flag_q;
  reg fail_irq_en_q;
  reg failsafe_q;
  reg powerdown_n_q;
  reg timeout_n_q;
  reg [10:0] ost_cnt_q;
  reg [3:0] hold_cnt_q;
  reg [5:0] div_cnt_q;
  reg sample_q;
  reg latch_q;
  reg fault_seen_q;

  wire fail_monitor_enable = config_q[`CFG_FAIL_MONITOR_ENABLE_BIT];
  wire [2:0] pri_mode = config_q[`CFG_MODE_LSB+2:`CFG_MODE_LSB];
  wire crystal = (pri_mode == `MODE_LP) || (pri_mode == `MODE_XT) || (pri_mode == `MODE_HS);
  // Two-speed start-up only makes sense for crystals; the monitor forces it on.
  wire two_speed = crystal && (config_q[`CFG_IESO_BIT] || fail_monitor_enable);
  wire ctrl_wr = i_wr && (i_addr == `OFS_OSC_CTRL);
  wire irq_wr = i_wr && (i_addr == `OFS_IRQ);
  wire sleep_nop = i_sleep_op && i_irq_pending;
  wire sleep_take = i_sleep_op && !i_irq_pending;
  wire wake_evt = o_sleeping && (i_watchdog_timeout || i_irq_pending);
  wire on_primary = (scs_q == `SCS_PRIMARY) && !failsafe_q;
  wire mon_active = fail_monitor_enable && !o_sleeping && ((state_q == ST_PRIMARY) || (scs_q == `SCS_SECONDARY));
  wire sample_fall_div;
  wire sample_rise_div;
  wire fail_detect;

  // --------------------------------------------------------------------------
  // Monitor sample clock and latch
  // --------------------------------------------------------------------------
  // The divided clock toggles every 32 RC falls, giving a period of 64 RC cycles.
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 6'h00;
      sample_q <= 1'b0;
    end else if (rc_fall) begin
      div_cnt_q <= div_cnt_q + 6'h01;
      if (div_cnt_q == (`MON_DIV / 2) - 1) begin
        div_cnt_q <= 6'h00;
        sample_q <= ~sample_q;
      end
    end
  end
  assign sample_rise_div = rc_fall && (div_cnt_q == (`MON_DIV / 2) - 1) && !sample_q;
  assign sample_fall_div = rc_fall && (div_cnt_q == (`MON_DIV / 2) - 1) && sample_q;

  // A system edge in the same cycle as the sample rise still counts for the new window.
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= 1'b0;
    end else if ((scs_q == `SCS_SECONDARY) ? sec_fall : pri_fall) begin
      latch_q <= 1'b1;
    end else if (sample_rise_div) begin
      latch_q <= 1'b0;
    end
  end

  // The first window after monitoring starts is skipped so a fresh latch cannot misfire.
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_seen_q <= 1'b0;
    end else if (!mon_active) begin
      fault_seen_q <= 1'b0;
    end else if (sample_rise_div) begin
      fault_seen_q <= 1'b1;
    end
  end
  // During the start-up timer the monitor is idle, so a dead crystal raises nothing.
  assign fail_detect = mon_active && fault_seen_q && sample_fall_div && !latch_q && !failsafe_q;

  // --------------------------------------------------------------------------
  // Start-up sequence and clock selection
  // --------------------------------------------------------------------------
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_INTERNAL;
      ost_cnt_q <= 11'h000;
      hold_cnt_q <= 4'h0;
      running_flag_q <= 1'b0;
      failsafe_q <= 1'b0;
    end else begin
      if (fail_detect) begin
        failsafe_q <= 1'b1;
        state_q <= ST_INTERNAL;
        running_flag_q <= 1'b0;
      end else if (ctrl_wr || sleep_take) begin
        failsafe_q <= 1'b0;
        running_flag_q <= 1'b0;
        state_q <= ST_INTERNAL;
      end else begin
        case (state_q)
          ST_INTERNAL: begin
            if (on_primary && !o_sleeping) begin
              ost_cnt_q <= 11'h000;
              // Without a crystal there is nothing to stabilise.
              state_q <= two_speed ? ST_OST : ST_PRIMARY;
              running_flag_q <= !two_speed;
            end
          end
          ST_OST: begin
            if (pri_fall) begin
              ost_cnt_q <= ost_cnt_q + 11'h001;
              if (ost_cnt_q == `OST_CYCLES - 11'h001) begin
                state_q <= ST_WAIT_RC;
              end
            end
          end
          ST_WAIT_RC: begin
            if (rc_fall) begin
              running_flag_q <= 1'b1;
              hold_cnt_q <= 4'h0;
              state_q <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            if (pri_fall) begin
              hold_cnt_q <= hold_cnt_q + 4'h1;
              if (hold_cnt_q == `HOLD_EDGES - 4'h1) begin
                state_q <= ST_PRIMARY;
              end
            end
          end
          ST_PRIMARY: begin
            state_q <= ST_PRIMARY;
          end
          default: begin
            state_q <= ST_INTERNAL;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  // After reset both fields are zero, so the core selects the primary and the internal clock is the RC at 31.25 kHz.
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      scs_q <= CTRL_RESET[`CTRL_SCS_LSB+1:`CTRL_SCS_LSB];
      internal_freq_select_q <= CTRL_RESET[`CTRL_INTERNAL_FREQ_SELECT_LSB+2:`CTRL_INTERNAL_FREQ_SELECT_LSB];
      config_q <= `RST_CONFIG;
      fail_flag_q <= 1'b0;
      fail_irq_en_q <= 1'b0;
    end else begin
      if (fail_detect) begin
        scs_q <= `SCS_INTERNAL;
      end else if (ctrl_wr) begin
        scs_q <= i_wdata[`CTRL_SCS_LSB+1:`CTRL_SCS_LSB];
        internal_freq_select_q <= i_wdata[`CTRL_INTERNAL_FREQ_SELECT_LSB+2:`CTRL_INTERNAL_FREQ_SELECT_LSB];
      end
      if (i_wr && (i_addr == `OFS_CONFIG)) begin
        config_q <= i_wdata;
      end
      if (irq_wr) begin
        fail_irq_en_q <= i_wdata[1];
      end
      // The set wins; the clear leaves the fail-safe clock in place.
      if (fail_detect) begin
        fail_flag_q <= 1'b1;
      end else if (irq_wr && i_wdata[0]) begin
        fail_flag_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sleep and wake
  // --------------------------------------------------------------------------
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_sleeping <= 1'b0;
      powerdown_n_q <= 1'b1;
      timeout_n_q <= 1'b1;
      o_wake <= 1'b0;
      o_irq_vector <= 1'b0;
      o_watchdog_reset <= 1'b0;
    end else begin
      o_wake <= wake_evt;
      o_irq_vector <= wake_evt && !i_watchdog_timeout && i_global_irq_enable;
      o_watchdog_reset <= (sleep_take && !o_sleeping) || i_watchdog_clear_op || fail_detect;
      if (sleep_take && !o_sleeping) begin
        o_sleeping <= 1'b1;
        powerdown_n_q <= 1'b0;
        timeout_n_q <= 1'b1;
      end else if (wake_evt) begin
        o_sleeping <= 1'b0;
        if (i_watchdog_timeout) begin
          timeout_n_q <= 1'b0;
        end
      end else if (i_watchdog_clear_op) begin
        powerdown_n_q <= 1'b1;
        timeout_n_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs and read port
  // --------------------------------------------------------------------------
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_clk_sel <= `SCS_INTERNAL;
      o_clk_hold_low <= 1'b0;
      o_osc_driver_en <= 1'b1;
      o_osc_fail_irq <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      o_clk_sel <= (o_sleeping || (on_primary && state_q != ST_PRIMARY) || failsafe_q) ?
                   `SCS_INTERNAL : scs_q;
      o_clk_hold_low <= (state_q == ST_HOLD);
      o_osc_driver_en <= !o_sleeping && !(sleep_take && !o_sleeping);
      o_osc_fail_irq <= fail_flag_q && fail_irq_en_q;
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `OFS_OSC_CTRL: o_rdata <= {1'b0, internal_freq_select_q, 2'b00, scs_q};
          `OFS_OSC_STATUS: o_rdata <= {4'h0, sleep_nop, o_sleeping, failsafe_q, running_flag_q};
          `OFS_IRQ: o_rdata <= {6'h00, fail_irq_en_q, fail_flag_q};
          `OFS_POWER_STATUS: o_rdata <= {6'h00, timeout_n_q, powerdown_n_q};
          `OFS_CONFIG: o_rdata <= config_q;
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// ---- shared/clock_supervisor_regs.vh ----
// Constants for the clock supervisor: register offsets, field positions, reset values, timing counts.
// Assumes a plain register port with one-cycle read latency and a 40 MHz system clock.
`ifndef CLOCK_SUPERVISOR_REGS_VH
`define CLOCK_SUPERVISOR_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_OSC_CTRL 4'h0
`define OFS_OSC_STATUS 4'h1
`define OFS_IRQ 4'h2
`define OFS_POWER_STATUS 4'h3
`define OFS_CONFIG 4'h4

// ----------------------------------------------------------------------------
// Field positions and encodings
// ----------------------------------------------------------------------------
`define CTRL_SCS_LSB 0
`define CTRL_INTERNAL_FREQ_SELECT_LSB 4
`define SCS_PRIMARY 2'b00
`define SCS_SECONDARY 2'b01
`define SCS_INTERNAL 2'b10
`define CFG_FAIL_MONITOR_ENABLE_BIT 0
`define CFG_IESO_BIT 1
`define CFG_MODE_LSB 2
`define MODE_LP 3'h0
`define MODE_XT 3'h1
`define MODE_HS 3'h2
`define MODE_EC 3'h3
`define MODE_RC 3'h4
`define MODE_INTERNAL_SLOW_RC 3'h5
`define RST_CTRL 8'h00
`define RST_CONFIG 8'h00

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define OST_CYCLES 11'h400
`define HOLD_EDGES 4'h8
`define MON_DIV 7'h40
`define RC_FREQ_HZ 31250
`define CLK_FREQ_HZ 40000000

`endif

// ---- dv/clock_supervisor_monitor.sv ----
// Concurrent checks on the clock supervisor's ports.
// Assumes the bind below attaches it to every clock_supervisor instance.
`timescale 1ns/1ps
module clock_supervisor_monitor (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_sleep_op,
  input wire i_watchdog_clear_op,
  input wire i_watchdog_timeout,
  input wire i_irq_pending,
  input wire i_global_irq_enable,
  input wire [3:0] i_addr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire [1:0] o_clk_sel,
  input wire o_clk_hold_low,
  input wire o_osc_driver_en,
  input wire o_sleeping,
  input wire o_watchdog_reset,
  input wire o_wake,
  input wire o_irq_vector
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  reset_source_a: assert property ($rose(i_rst_n) |-> o_clk_sel == 2'b10)
    else $error("clock source not internal at reset release");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read answer cycle");
  unmapped_zero_a: assert property ($past(i_rd) && $past(i_addr) > 4'h4 |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  sleep_taken_a: assert property (i_sleep_op && !i_irq_pending && !o_sleeping
    |=> o_sleeping && o_watchdog_reset && !o_osc_driver_en)
    else $error("sleep entry incomplete");
  sleep_nop_a: assert property (i_sleep_op && i_irq_pending && !o_sleeping |=> !o_sleeping)
    else $error("sleep taken with interrupt pending");
  driver_off_a: assert property (o_sleeping |-> !o_osc_driver_en)
    else $error("oscillator driver on while sleeping");
  wake_source_a: assert property (o_sleeping && (i_watchdog_timeout || i_irq_pending)
    |-> ##[1:3] $fell(o_sleeping))
    else $error("no wake after wake event");
  wake_pulse_a: assert property ($fell(o_sleeping) |-> o_wake)
    else $error("wake pulse missing");
  vector_gate_a: assert property (o_irq_vector |-> $past(i_global_irq_enable))
    else $error("vector without global enable");
  hold_before_a: assert property (o_clk_hold_low |-> o_clk_sel != 2'b00)
    else $error("primary selected during hold");
  clear_op_a: assert property (i_watchdog_clear_op |=> o_watchdog_reset)
    else $error("watchdog clear not passed on");
endmodule

bind clock_supervisor clock_supervisor_monitor u_mon (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sleep_op(i_sleep_op), .i_watchdog_clear_op(i_watchdog_clear_op),
  .i_watchdog_timeout(i_watchdog_timeout), .i_irq_pending(i_irq_pending),
  .i_global_irq_enable(i_global_irq_enable), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_clk_sel(o_clk_sel), .o_clk_hold_low(o_clk_hold_low), .o_osc_driver_en(o_osc_driver_en),
  .o_sleeping(o_sleeping), .o_watchdog_reset(o_watchdog_reset), .o_wake(o_wake),
  .o_irq_vector(o_irq_vector));

// ---- dv/osc_pins_model.sv ----
// Oscillator pins seen by the supervisor: slow RC, primary crystal, secondary.
// Rates are scaled up so a monitor window is about 1024 system cycles.
`timescale 1ns/1ps
module osc_pins_model (
  input wire i_primary_run,
  input wire i_secondary_run,
  input wire i_driver_en,
  output logic o_rc_clk,
  output logic o_primary_clk,
  output logic o_secondary_clk
);
  // ---------------------------------------------------------------------------
  // Oscillators
  // ---------------------------------------------------------------------------
  // A stopped or undriven crystal stands still, so the monitor sees no edges.
  initial begin
    o_rc_clk = 1'b0;
    o_primary_clk = 1'b0;
    o_secondary_clk = 1'b0;
  end
  always #200 o_rc_clk = ~o_rc_clk;
  always #125 if (i_primary_run && i_driver_en) o_primary_clk = ~o_primary_clk;
  always #250 if (i_secondary_run) o_secondary_clk = ~o_secondary_clk;
endmodule

// ---- dv/clock_supervisor_bench.sv ----
// Self-checking bench for the clock supervisor: start-up, fail-safe, sleep and wake.
// Assumes the oscillator pin model and the register constants header.
`timescale 1ns/1ps
`include "clock_supervisor_regs.vh"
module clock_supervisor_bench;
  logic i_clk = 0, i_rst_n = 0, pri_run = 1, sec_run = 0, i_wr = 0, i_rd = 0;
  logic i_sleep_op = 0, i_watchdog_clear_op = 0, i_watchdog_timeout = 0;
  logic i_irq_pending = 0, i_global_irq_enable = 0;
  logic [3:0] i_addr = 0;
  logic [7:0] i_wdata = 0, o_rdata;
  logic [1:0] o_clk_sel;
  logic o_clk_hold_low, o_osc_driver_en, o_sleeping, o_watchdog_reset, o_wake, o_irq_vector, o_osc_fail_irq;
  wire rc, pri, sec;
  int n_fail = 0, tests_run = 0, cyc = 0, n_hold = 0, n_wd = 0, n_vec = 0, mark;

  always #12.5 i_clk = ~i_clk;

  osc_pins_model osc (.i_primary_run(pri_run), .i_secondary_run(sec_run), .i_driver_en(o_osc_driver_en),
    .o_rc_clk(rc), .o_primary_clk(pri), .o_secondary_clk(sec));
  clock_supervisor dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rc_clk(rc), .i_primary_clk(pri),
    .i_secondary_clk(sec), .i_sleep_op(i_sleep_op), .i_watchdog_clear_op(i_watchdog_clear_op),
    .i_watchdog_timeout(i_watchdog_timeout), .i_irq_pending(i_irq_pending),
    .i_global_irq_enable(i_global_irq_enable), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_clk_sel(o_clk_sel), .o_clk_hold_low(o_clk_hold_low),
    .o_osc_driver_en(o_osc_driver_en), .o_sleeping(o_sleeping), .o_watchdog_reset(o_watchdog_reset),
    .o_wake(o_wake), .o_irq_vector(o_irq_vector), .o_osc_fail_irq(o_osc_fail_irq));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
  endtask

  task automatic rdx(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 0;
    @(negedge i_clk);
    check(o_rdata, exp);
  endtask

  task automatic do_sleep();
    @(posedge i_clk);
    i_sleep_op <= 1;
    @(posedge i_clk);
    i_sleep_op <= 0;
    @(negedge i_clk);
  endtask

  // Polls are bounded so a stuck design ends in a mismatch, not a hang.
  task automatic wait_sel(input logic [1:0] v, input int lim);
    for (int k = 0; k < lim && o_clk_sel !== v; k++) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic wait_awake();
    for (int k = 0; k < 20 && o_sleeping !== 1'b0; k++) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (o_clk_hold_low === 1'b1) n_hold++;
    if (o_watchdog_reset === 1'b1) n_wd++;
    if (o_irq_vector === 1'b1) n_vec++;
    if (cyc == 90000) begin
      n_fail++;
      summarize();
    end
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1;
    @(negedge i_clk);
    check(o_clk_sel, 2'b10);
    repeat (3) @(posedge i_clk);
    rdx(`OFS_OSC_CTRL, `RST_CTRL);
    rdx(`OFS_CONFIG, `RST_CONFIG);
    rdx(4'hF, 8'h00);
    wr(`OFS_CONFIG, 8'h05);
    mark = n_wd;
    @(posedge i_clk);
    i_watchdog_clear_op <= 1;
    @(posedge i_clk);
    i_watchdog_clear_op <= 0;
    do_sleep();
    check(o_sleeping, 1);
    check(o_osc_driver_en, 0);
    rdx(`OFS_POWER_STATUS, 8'h02);
    check(8'(n_wd - mark), 8'h02);
    @(posedge i_clk);
    i_watchdog_timeout <= 1;
    @(posedge i_clk);
    i_watchdog_timeout <= 0;
    wait_awake();
    check(o_sleeping, 0);
    rdx(`OFS_POWER_STATUS, 8'h00);
    check(o_clk_sel, 2'b10);
    mark = n_hold;
    repeat (5000) @(posedge i_clk);
    rdx(`OFS_OSC_STATUS, 8'h00);
    check(o_clk_sel, 2'b10);
    wait_sel(2'b00, 20000);
    check(o_clk_sel, 2'b00);
    check(8'(n_hold > mark), 8'h01);
    rdx(`OFS_OSC_STATUS, 8'h01);
    // A dead crystal: the pin stops toggling while the primary is selected.
    mark = n_wd;
    pri_run = 0;
    wait_sel(2'b10, 6000);
    check(o_clk_sel, 2'b10);
    rdx(`OFS_IRQ, 8'h01);
    rdx(`OFS_OSC_STATUS, 8'h02);
    rdx(`OFS_OSC_CTRL, 8'h02);
    check(8'(n_wd > mark), 8'h01);
    check(o_osc_fail_irq, 0);
    wr(`OFS_IRQ, 8'h02);
    repeat (2) @(negedge i_clk);
    check(o_osc_fail_irq, 1);
    wr(`OFS_IRQ, 8'h03);
    rdx(`OFS_IRQ, 8'h02);
    check(o_clk_sel, 2'b10);
    rdx(`OFS_OSC_STATUS, 8'h02);
    pri_run = 1;
    wr(`OFS_OSC_CTRL, 8'h02);
    rdx(`OFS_OSC_STATUS, 8'h00);
    mark = n_wd;
    @(posedge i_clk);
    i_irq_pending <= 1;
    do_sleep();
    check(o_sleeping, 0);
    rdx(`OFS_POWER_STATUS, 8'h00);
    check(8'(n_wd - mark), 8'h00);
    for (int g = 0; g < 2; g++) begin
      @(posedge i_clk);
      i_irq_pending <= 0;
      i_global_irq_enable <= g[0];
      do_sleep();
      check(o_sleeping, 1);
      mark = n_vec;
      @(posedge i_clk);
      i_irq_pending <= 1;
      wait_awake();
      check(o_sleeping, 0);
      repeat (4) @(posedge i_clk);
      check(8'(n_vec - mark), 8'(g));
    end
    // A secondary oscillator that never runs is caught once it is selected.
    wr(`OFS_OSC_CTRL, 8'h01);
    wait_sel(2'b01, 20);
    check(o_clk_sel, 2'b01);
    mark = n_wd;
    wait_sel(2'b10, 4000);
    check(o_clk_sel, 2'b10);
    check(o_osc_fail_irq, 1);
    rdx(`OFS_OSC_CTRL, 8'h02);
    check(8'(n_wd > mark), 8'h01);
    // An external clock primary needs no start-up count and is watched at once.
    wr(`OFS_IRQ, 8'h01);
    wr(`OFS_CONFIG, 8'h0D);
    mark = n_hold;
    wr(`OFS_OSC_CTRL, 8'h00);
    wait_sel(2'b00, 20);
    check(o_clk_sel, 2'b00);
    check(8'(n_hold - mark), 8'h00);
    rdx(`OFS_OSC_STATUS, 8'h01);
    pri_run = 0;
    wait_sel(2'b10, 4000);
    check(o_clk_sel, 2'b10);
    rdx(`OFS_IRQ, 8'h01);
    summarize();
  end
endmodule
